//--- dv/link_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module link_far_end (
  input wire logic link_clk,
  input wire logic rstn,
  input wire logic send_en,
  input wire logic err_en,
  input wire logic clk_bad,
  output link_bist_pkg::link_word_s word
);
  logic [6:0] lfsr_r;
  logic [6:0] s;
  logic [23:0] d;
  logic code_b_r;
  // 24 prbs bits per word, first bit in bit 0
  always @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lfsr_r <= link_bist_pkg::PRBS_SEED;
      code_b_r <= 1'b0;
      word <= '0;
    end else begin
      s = lfsr_r;
      for (int i = 0; i < 24; i++) begin
        d[i] = s[6] ^ s[5];
        s = {s[5:0], d[i]};
      end
      lfsr_r <= s;
      code_b_r <= ~code_b_r;
      word.clk_low <= clk_bad;
      word.clk_high <= ~clk_bad;
      word.ctrl <= !send_en ? link_bist_pkg::CODE_IDLE :
        code_b_r ? link_bist_pkg::CODE_B : link_bist_pkg::CODE_A;
      // one flipped bit keeps the count inside 1..24
      word.data <= d ^ {23'h0, err_en};
    end
  end
endmodule
`default_nettype wire

//--- dv/serial_link_bist_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module link_bist_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic self_test_enable_pin,
  input wire logic [28:0] link_word_in,
  input wire logic [23:0] data_out,
  input wire logic [2:0] video_ctrl_out,
  input wire logic video_out_en,
  input wire logic result_pin,
  input wire logic lock_pin
);
  // single domain, so one clocking and one reset serve all
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_ctrl_off;
    !video_out_en |-> video_ctrl_out == 3'h0;
  endproperty
  a_ctrl_off: assert property (p_ctrl_off)
    else $error("ctrl live in test");
  property p_board;
    (self_test_enable_pin && !video_out_en)[*4] ##0
      data_out == link_bist_pkg::CHECKER_A |=>
      data_out == link_bist_pkg::CHECKER_B;
  endproperty
  a_board: assert property (p_board)
    else $error("no checkerboard");
  property p_in_test;
    (self_test_enable_pin && !video_out_en)[*5] |-> result_pin;
  endproperty
  a_in_test: assert property (p_in_test)
    else $error("result low in test");
  property p_hold;
    (!self_test_enable_pin)[*6] |-> $stable(result_pin);
  endproperty
  a_hold: assert property (p_hold)
    else $error("verdict moved");
  property p_fall;
    $fell(result_pin) |-> !self_test_enable_pin;
  endproperty
  a_fall: assert property (p_fall)
    else $error("verdict while enabled");
  property p_rise;
    $rose(result_pin) |-> $past(self_test_enable_pin, 2);
  endproperty
  a_rise: assert property (p_rise)
    else $error("verdict cleared early");
  // lock crosses capture, gray sync and the fifo, hence the window
  property p_lock_drop;
    link_word_in[28:27] != 2'b01 |-> ##[0:12] !lock_pin;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock kept");
  property p_lock_rise;
    $rose(lock_pin) |-> link_word_in[28:27] == 2'b01;
  endproperty
  a_lock_rise: assert property (p_lock_rise)
    else $error("lock on bad bits");
endmodule
bind serial_link_bist_checker link_bist_props i_link_bist_props (
  .core_clk(core_clk),
  .rstn(rstn),
  .self_test_enable_pin(self_test_enable_pin),
  .link_word_in(link_word_in),
  .data_out(data_out),
  .video_ctrl_out(video_ctrl_out),
  .video_out_en(video_out_en),
  .result_pin(result_pin),
  .lock_pin(lock_pin)
);
`default_nettype wire

//--- dv/serial_link_bist_checker_tb.sv
`timescale 1ns/1ns
`default_nettype none
module serial_link_bist_checker_tb;
  logic core_clk = 0;
  logic link_clk = 0;
  logic rstn = 0;
  logic send_en = 0;
  logic test_en = 0;
  logic err_en = 0;
  logic clk_bad = 0;
  logic [26:0] vid = 27'h0;
  link_bist_pkg::link_word_s rx_word;
  logic [23:0] data_out;
  logic [23:0] last_data;
  logic [23:0] got;
  logic [25:0] ent;
  logic [25:0] exp_q[$];
  logic video_out_en;
  logic result_pin;
  logic lock_pin;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 70;
  int pulses = 0;
  event chk_ev;
  serial_link_bist_checker i_serial_link_bist_checker (
    .core_clk(core_clk), .rstn(rstn), .ce(1'b1),
    .link_clk(link_clk), .link_rstn(rstn),
    .sender_test_enable_pin(send_en), .self_test_enable_pin(test_en),
    .video_in(vid[23:0]), .video_ctrl_in(vid[26:24]),
    .link_word_out(), .link_word_in(rx_word), .data_out(data_out),
    .video_ctrl_out(), .video_out_en(video_out_en),
    .result_pin(result_pin), .lock_pin(lock_pin), .link_ready()
  );
  link_far_end i_link_far_end (
    .link_clk(link_clk), .rstn(rstn), .send_en(send_en),
    .err_en(err_en), .clk_bad(clk_bad), .word(rx_word)
  );
  initial forever #5 core_clk = ~core_clk;
  // link clock on its own phase, 15 ns
  initial begin
    #3;
    forever begin
      #7 link_clk = 1;
      #8 link_clk = 0;
    end
  end
  // random video keeps the sender inputs busy
  always @(posedge core_clk) begin
    vid <= 27'($random(seed));
    last_data <= data_out;
  end
  task automatic summarize;
    $display("comparisons=%0d bad=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // error pulses are counted while the checker enable is high
  always @(negedge result_pin) if (test_en) pulses++;
  // look just after the falling edge, once any error pulse has ended
  task automatic expect_out(logic [1:0] sel, logic [23:0] v);
    @(negedge core_clk);
    #1;
    exp_q.push_back({sel, v});
    ->chk_ev;
  endtask
  // 0 result, 1 lock, 2 video enable, 3 checkerboard toggle
  always @(chk_ev) begin
    while (exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      case (ent[25:24])
        2'h0: got = {23'h0, result_pin};
        2'h1: got = {23'h0, lock_pin};
        2'h2: got = {23'h0, video_out_en};
        default: got = (data_out ^ last_data) &
          {24{data_out === link_bist_pkg::CHECKER_A ||
          data_out === link_bist_pkg::CHECKER_B}};
      endcase
      comparisons++;
      if (got !== ent[23:0]) begin
        bad_count++;
        $display("BAD t=%0t exp=%h got=%h", $time, ent[23:0], got);
      end
    end
  end
  task automatic run_test(logic err, logic verdict);
    @(posedge core_clk);
    pulses = 0;
    send_en <= 1'b1;
    err_en <= err;
    repeat (20) @(posedge core_clk);
    test_en <= 1'b1;
    repeat (40) @(posedge core_clk);
    expect_out(2'h2, 24'h0);
    expect_out(2'h3, 24'hffffff);
    expect_out(2'h0, 24'h1);
    @(posedge core_clk);
    test_en <= 1'b0;
    repeat (10) @(posedge core_clk);
    expect_out(2'h0, {23'h0, verdict});
    comparisons++;
    if ((pulses != 0) != err) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, err, pulses != 0);
    end
    @(posedge core_clk);
    send_en <= 1'b0;
    err_en <= 1'b0;
    repeat (30) @(posedge core_clk);
    expect_out(2'h0, {23'h0, verdict});
    $display("test done, verdict %h", verdict);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    expect_out(2'h0, 24'h1);
    repeat (40) @(posedge core_clk);
    expect_out(2'h1, 24'h1);
    run_test(1'b0, 1'b1);
    run_test(1'b1, 1'b0);
    run_test(1'b0, 1'b1);
    run_test(1'b1, 1'b0);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    expect_out(2'h0, 24'h1);
    repeat (40) @(posedge core_clk);
    clk_bad <= 1'b1;
    repeat (20) @(posedge core_clk);
    expect_out(2'h1, 24'h0);
    clk_bad <= 1'b0;
    repeat (40) @(posedge core_clk);
    expect_out(2'h1, 24'h1);
    summarize();
  end
  // watchdog well past the expected few hundred cycles
  initial begin
    #50000;
    bad_count++;
    $display("watchdog expired");
    summarize();
  end
endmodule
`default_nettype wire

//--- src/link_bist_pkg.sv
package link_bist_pkg;
  // payload width, fifo depth and pattern width
  localparam int unsigned PAYLOAD_W = 24;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned PRBS_W = 7;
  // prbs7 taps x^7 + x^6 + 1
  localparam int unsigned PRBS_TAP_HI = 6;
  localparam int unsigned PRBS_TAP_LO = 5;
  localparam logic [6:0] PRBS_SEED = 7'h7f;
  // command code words carried in the control field while testing
  localparam logic [2:0] CODE_IDLE = 3'h0;
  localparam logic [2:0] CODE_A = 3'h5;
  localparam logic [2:0] CODE_B = 3'h2;
  // checkerboard halves
  localparam logic [23:0] CHECKER_A = 24'haaaaaa;
  localparam logic [23:0] CHECKER_B = 24'h555555;
  // errored payload bound and lock behaviour
  localparam logic [4:0] ERR_MAX = 5'h18;
  localparam logic [3:0] LOCK_GOOD_CNT = 4'h8;

  // one received word: clock bits, control field, payload
  typedef struct packed {
    logic clk_low;
    logic clk_high;
    logic [2:0] ctrl;
    logic [23:0] data;
  } link_word_s;
endpackage

//--- src/serial_link_bist_checker.sv
// Summary of operation
// - With the test enable high and pixel clock running, the sender emits a prbs7 payload at full speed.
// - In test mode the receiver tracks the incoming prbs7 and compares each payload to the expected one.
// - A payload with one to twenty-four bit errors pulls the result pin low for the first half of a core clock period.
// - Checking runs only while the receiver test enable is high and stops when it falls.
// - After checking stops the result pin holds high for no errors and low for any error.
// - The held verdict lasts until a new test, a reset or power down.
// - During the test the parallel outputs show an alternating checkerboard.
// - On seeing either command code in the control field the colour and control outputs are disabled.
// - Lock goes low whenever the embedded clock bits fail to form the expected clock.
// - Only payload bits are checked; embedded clock bits are watched by lock.
`timescale 1ns/1ns
`default_nettype none

module link_word_fifo #(
  parameter int unsigned WIDTH = 29,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign out_valid = (wr_r != rd_r);
  assign out_data = mem[rd_r[AW-1:0]];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  // storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

module serial_link_bist_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic link_rstn,
  input wire logic sender_test_enable_pin,
  input wire logic self_test_enable_pin,
  input wire logic [23:0] video_in,
  input wire logic [2:0] video_ctrl_in,
  output logic [28:0] link_word_out,
  input wire logic [28:0] link_word_in,
  output logic [23:0] data_out,
  output logic [2:0] video_ctrl_out,
  output logic video_out_en,
  output logic result_pin,
  output logic lock_pin,
  output logic link_ready
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_HOLD = 3'b100
  } chk_state_e;

  // ---- sender side, link clock ----
  logic [1:0] snd_en_sync_r;
  logic [6:0] gen_r;
  logic [23:0] gen_word;
  logic clk_phase_r;
  link_bist_pkg::link_word_s tx_nxt;

  // enable pin is asynchronous to the link clock
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      snd_en_sync_r <= '0;
    end else begin
      snd_en_sync_r <= {snd_en_sync_r[0], sender_test_enable_pin};
    end
  end

  // unroll 24 prbs steps per payload
  always_comb begin
    logic [6:0] s;
    s = gen_r;
    gen_word = '0;
    for (int i = 0; i < 24; i++) begin
      s = {s[5:0], s[link_bist_pkg::PRBS_TAP_HI] ^ s[link_bist_pkg::PRBS_TAP_LO]};
      gen_word[i] = s[0];
    end
  end

  always_comb begin
    tx_nxt.clk_low = 1'b0;
    tx_nxt.clk_high = 1'b1;
    if (snd_en_sync_r[1]) begin
      tx_nxt.data = gen_word;
      tx_nxt.ctrl = clk_phase_r ? link_bist_pkg::CODE_A : link_bist_pkg::CODE_B;
    end else begin
      tx_nxt.data = video_in;
      tx_nxt.ctrl = video_ctrl_in;
    end
  end

  // one payload per link clock, full rate
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      gen_r <= link_bist_pkg::PRBS_SEED;
      clk_phase_r <= 1'b0;
      link_word_out <= '0;
    end else begin
      clk_phase_r <= ~clk_phase_r;
      link_word_out <= tx_nxt;
      if (snd_en_sync_r[1]) begin
        // newest bit belongs in bit 0, so the slice is reversed
        gen_r <= {<<{gen_word[23:17]}};
      end
    end
  end

  // ---- receive path crosses through an async fifo ----
  logic [28:0] rx_cap_r;
  logic [3:0] lwr_bin_r;
  logic [3:0] lwr_gray_r;
  logic [3:0] lrd_gray_s1_r;
  logic [3:0] lrd_gray_s2_r;
  logic [3:0] crd_bin_r;
  logic [3:0] crd_gray_r;
  logic [28:0] amem [link_bist_pkg::FIFO_DEPTH];
  logic afull;

  assign afull = (lwr_gray_r == {~lrd_gray_s2_r[3:2], lrd_gray_s2_r[1:0]});

  // words drop when the core falls behind; lock only watches clock bits and does not see it
  always_ff @(posedge link_clk) begin
    if (!afull) begin
      amem[lwr_bin_r[2:0]] <= rx_cap_r;
    end
  end

  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      rx_cap_r <= '0;
      lwr_bin_r <= '0;
      lwr_gray_r <= '0;
      lrd_gray_s1_r <= '0;
      lrd_gray_s2_r <= '0;
    end else begin
      rx_cap_r <= link_word_in;
      lrd_gray_s1_r <= crd_gray_r;
      lrd_gray_s2_r <= lrd_gray_s1_r;
      if (!afull) begin
        lwr_bin_r <= lwr_bin_r + 4'h1;
        lwr_gray_r <= (lwr_bin_r + 4'h1) ^ ((lwr_bin_r + 4'h1) >> 1);
      end
    end
  end

  // ---- core domain ----
  logic [3:0] cwr_gray_s1_r;
  logic [3:0] cwr_gray_s2_r;
  logic a_valid;
  logic a_pop;
  logic q_ready;
  logic w_valid;
  logic [28:0] w_data;
  link_bist_pkg::link_word_s w;

  assign a_valid = (crd_gray_r != cwr_gray_s2_r);
  assign a_pop = ce && a_valid && q_ready;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      crd_bin_r <= '0;
      crd_gray_r <= '0;
      cwr_gray_s1_r <= '0;
      cwr_gray_s2_r <= '0;
    end else if (ce) begin
      cwr_gray_s1_r <= lwr_gray_r;
      cwr_gray_s2_r <= cwr_gray_s1_r;
      if (a_pop) begin
        crd_bin_r <= crd_bin_r + 4'h1;
        crd_gray_r <= (crd_bin_r + 4'h1) ^ ((crd_bin_r + 4'h1) >> 1);
      end
    end
  end

  link_word_fifo #(
    .WIDTH(29),
    .DEPTH(link_bist_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(a_valid),
    .in_ready(q_ready),
    .in_data(amem[crd_bin_r[2:0]]),
    .out_valid(w_valid),
    .out_ready(1'b1),
    .out_data(w_data)
  );

  assign w = w_data;

  // enable pin synchroniser
  logic [1:0] en_sync_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_sync_r <= '0;
    end else if (ce) begin
      en_sync_r <= {en_sync_r[0], self_test_enable_pin};
    end
  end

  // self-synchronising expected payload from last 7 received bits
  logic [6:0] chk_seed_r;
  logic [23:0] exp_word;
  logic [4:0] err_cnt;
  always_comb begin
    logic [6:0] s;
    s = chk_seed_r;
    exp_word = '0;
    err_cnt = '0;
    for (int i = 0; i < 24; i++) begin
      exp_word[i] = s[link_bist_pkg::PRBS_TAP_HI] ^ s[link_bist_pkg::PRBS_TAP_LO];
      s = {s[5:0], w.data[i]};
      err_cnt = err_cnt + 5'(w.data[i] ^ exp_word[i]);
    end
  end

  chk_state_e state_r;
  logic seeded_r;
  logic fail_r;
  logic mode_seen_r;
  logic start;
  logic word_err;

  assign start = en_sync_r[1] && mode_seen_r;
  assign word_err = seeded_r && (err_cnt != 5'h00) && (err_cnt <= link_bist_pkg::ERR_MAX);

  // test mode recognised from command codes in control field
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_seen_r <= 1'b0;
    end else if (ce && w_valid) begin
      mode_seen_r <= (w.ctrl == link_bist_pkg::CODE_A) || (w.ctrl == link_bist_pkg::CODE_B);
    end
  end

  // checking state machine
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      seeded_r <= 1'b0;
      fail_r <= 1'b0;
      chk_seed_r <= '0;
    end else if (ce) begin
      if (w_valid) begin
        chk_seed_r <= {<<{w.data[23:17]}};
      end
      case (state_r)
        ST_IDLE, ST_HOLD: begin
          if (start) begin
            state_r <= ST_CHECK;
            fail_r <= 1'b0;
            seeded_r <= 1'b0;
          end
        end
        ST_CHECK: begin
          if (!en_sync_r[1]) begin
            state_r <= ST_HOLD;
          end else if (w_valid) begin
            seeded_r <= 1'b1;
            if (word_err) begin
              fail_r <= 1'b1;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // error pulse: one toggle per errored payload, caught up on the falling
  // edge, so the xor is high for the first half period only; a level
  // pulse would merge back-to-back errors into one
  logic err_tgl_r;
  logic err_tgl_n_r;
  logic result_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      err_tgl_r <= 1'b0;
    end else if (ce) begin
      if ((state_r == ST_CHECK) && en_sync_r[1] && w_valid &&
          word_err) begin
        err_tgl_r <= ~err_tgl_r;
      end
    end
  end
  always_ff @(negedge core_clk or negedge rstn) begin
    if (!rstn) begin
      err_tgl_n_r <= 1'b0;
    end else begin
      err_tgl_n_r <= err_tgl_r;
    end
  end

  // result high idle and in test, verdict afterwards
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result_r <= 1'b1;
    end else if (ce) begin
      if (state_r == ST_HOLD) begin
        result_r <= !fail_r;
      end else begin
        result_r <= 1'b1;
      end
    end
  end

  // a half-period pulse needs both edges, so the pin gates the verdict
  assign result_pin = result_r && !(err_tgl_r ^ err_tgl_n_r);

  // lock: embedded clock bits must read low then high
  logic [3:0] lock_cnt_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lock_cnt_r <= '0;
      lock_pin <= 1'b0;
    end else if (ce && w_valid) begin
      if (w.clk_low || !w.clk_high) begin
        lock_cnt_r <= '0;
        lock_pin <= 1'b0;
      end else if (lock_cnt_r != link_bist_pkg::LOCK_GOOD_CNT) begin
        lock_cnt_r <= lock_cnt_r + 4'h1;
      end else begin
        lock_pin <= 1'b1;
      end
    end
  end

  // parallel outputs: checkerboard in test, zero while command codes are seen, video otherwise
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      data_out <= '0;
      video_ctrl_out <= '0;
      video_out_en <= 1'b1;
      link_ready <= 1'b0;
    end else if (ce) begin
      link_ready <= q_ready;
      video_out_en <= !mode_seen_r;
      if (state_r == ST_CHECK) begin
        data_out <= (data_out == link_bist_pkg::CHECKER_A) ?
          link_bist_pkg::CHECKER_B : link_bist_pkg::CHECKER_A;
        video_ctrl_out <= '0;
      end else if (mode_seen_r) begin
        data_out <= '0;
        video_ctrl_out <= '0;
      end else if (w_valid) begin
        data_out <= w.data;
        video_ctrl_out <= w.ctrl;
      end
    end
  end
endmodule

`default_nettype wire
